// File: src/sysctl_pkg.sv
// shared constants and types for the system control port block
package sysctl_pkg;

    // ==========================================================
    // port addresses
    localparam logic [15:0] SYSCTL_STATUS_ADDR = 16'h0061;
    localparam logic [15:0] RTC_INDEX_ADDR     = 16'h0070;
    localparam logic [15:0] RTC_DATA_ADDR      = 16'h0071;

    // ==========================================================
    // status port field positions
    localparam int TIMER2_GATE_POS  = 0;
    localparam int SPKR_DATA_POS    = 1;
    localparam int PARITY_DIS_POS   = 2;
    localparam int CHCK_DIS_POS     = 3;
    localparam int REFRESH_POS      = 4;
    localparam int TIMER2_OUT_POS   = 5;
    localparam int CHCK_LATCH_POS   = 6;
    localparam int PARITY_LATCH_POS = 7;

    // index port fields
    localparam int RTC_ADDR_W   = 7;
    localparam int NMI_MASK_POS = 7;

    // ==========================================================
    // reset values
    localparam logic [3:0] CTRL_RESET     = 4'h0;
    localparam logic [6:0] RTC_ADDR_RESET = 7'h00;
    localparam logic       NMI_MASK_RESET = 1'b0;

    // ==========================================================
    // timing
    localparam int REFRESH_PERIOD_NS = 15000;
    localparam int CLK_PERIOD_NS     = 5;

    // ==========================================================
    // cpu i/o request and rtc ram access carriers
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } io_req_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } rtc_req_t;

endpackage

// File: src/nmi_latch.sv
// channel check and parity latches with nmi combine
`timescale 1ns/100ps
`default_nettype none
module nmi_latch
    import sysctl_pkg::*;
(
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    // controls
    input  wire logic chck_dis_i,
    input  wire logic parity_dis_i,
    input  wire logic nmi_mask_i,
    // sources
    input  wire logic iochck_n_i,
    input  wire logic parity_err_i,
    // results
    output logic      chck_latch_o,
    output logic      parity_latch_o,
    output logic      nmi_o
);
    logic chck_reg;
    logic parity_reg;

    // disable has precedence, like the clear input of the latch
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            chck_reg <= 1'b0;
        end else if (chck_dis_i) begin
            chck_reg <= 1'b0;
        end else if (!iochck_n_i) begin
            chck_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            parity_reg <= 1'b0;
        end else if (parity_dis_i) begin
            parity_reg <= 1'b0;
        end else if (parity_err_i) begin
            parity_reg <= 1'b1;
        end
    end

    assign chck_latch_o   = chck_reg;
    assign parity_latch_o = parity_reg;
    // registered so nmi never glitches on a mask write
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            nmi_o <= 1'b0;
        end else begin
            nmi_o <= (chck_reg | parity_reg) & ~nmi_mask_i;
        end
    end
endmodule
`default_nettype wire

// File: src/sysctl_ports.sv
// at system control status port and rtc index/data ports
`timescale 1ns/100ps
`default_nettype none
module sysctl_ports
    import sysctl_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       sys_rst_i,
    // cpu i/o cycle
    input  wire io_req_t    io_req_i,
    output logic [7:0]      io_rdata_o,
    output logic            io_hit_o,
    // timer unit
    input  wire logic       timer1_pulse_i,
    input  wire logic       timer2_out_i,
    output logic            timer2_gate_o,
    // speaker
    output logic            speaker_o,
    // nmi sources and output
    input  wire logic       iochck_n_i,
    input  wire logic       parity_err_i,
    output logic            nmi_o,
    // rtc/cmos ram
    output rtc_req_t        rtc_req_o,
    input  wire logic [7:0] rtc_rdata_i
);
    // ==========================================================
    // decode
    function automatic logic addr_is(input logic [15:0] a,
                                     input logic [15:0] p);
        return a == p;
    endfunction

    logic status_sel;
    logic index_sel;
    logic data_sel;

    assign status_sel = addr_is(io_req_i.addr, SYSCTL_STATUS_ADDR);
    assign index_sel  = addr_is(io_req_i.addr, RTC_INDEX_ADDR);
    assign data_sel   = addr_is(io_req_i.addr, RTC_DATA_ADDR);
    assign io_hit_o   = (io_req_i.rd | io_req_i.wr)
                      & (status_sel | index_sel | data_sel);

    // one write strobe per port, shared by every field it loads
    logic status_wr;
    logic index_wr;

    assign status_wr = io_req_i.wr & status_sel;
    assign index_wr  = io_req_i.wr & index_sel;

    // ==========================================================
    // control bits 0-3
    logic [3:0] ctrl_reg;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= CTRL_RESET;
        end else if (status_wr) begin
            // bits 4-7 are read-only, writes there are dropped
            ctrl_reg <= io_req_i.wdata[3:0];
        end
    end

    assign timer2_gate_o = ctrl_reg[TIMER2_GATE_POS];

    // ==========================================================
    // control fields
    logic spkr_data;
    logic parity_dis;
    logic chck_dis;

    // disable bits read back as written and act on the latches directly
    assign spkr_data  = ctrl_reg[SPKR_DATA_POS];
    assign parity_dis = ctrl_reg[PARITY_DIS_POS];
    assign chck_dis   = ctrl_reg[CHCK_DIS_POS];

    // ==========================================================
    // refresh detect
    logic refresh_reg;

    // no dependence on isa refresh enable; software times with it
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            refresh_reg <= 1'b0;
        end else if (timer1_pulse_i) begin
            refresh_reg <= ~refresh_reg;
        end
    end

    // ==========================================================
    // timer 2 level and speaker
    logic t2_level;

    // gate low forces the readback and speaker term to 1
    assign t2_level = ctrl_reg[TIMER2_GATE_POS] ? timer2_out_i
                                                : 1'b1;

    logic speaker_next;

    // speaker is active low: only bit 1 with the timer 2 bit pulls it down
    assign speaker_next = ~(spkr_data & t2_level);

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            speaker_o <= 1'b1;
        end else begin
            speaker_o <= speaker_next;
        end
    end

    // ==========================================================
    // nmi latches
    logic chck_latch;
    logic parity_latch;
    logic nmi_mask_reg;

    nmi_latch u_nmi (
        .core_clk_i     (core_clk_i),
        .sys_rst_i      (sys_rst_i),
        .chck_dis_i     (chck_dis),
        .parity_dis_i   (parity_dis),
        .nmi_mask_i     (nmi_mask_reg),
        .iochck_n_i     (iochck_n_i),
        .parity_err_i   (parity_err_i),
        .chck_latch_o   (chck_latch),
        .parity_latch_o (parity_latch),
        .nmi_o          (nmi_o)
    );

    // ==========================================================
    // rtc index and nmi mask
    logic [6:0] rtc_addr_reg;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rtc_addr_reg <= RTC_ADDR_RESET;
        end else if (index_wr) begin
            rtc_addr_reg <= io_req_i.wdata[RTC_ADDR_W-1:0];
        end
    end

    // ==========================================================
    // nmi mask, shares the index write strobe
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            nmi_mask_reg <= NMI_MASK_RESET;
        end else if (index_wr) begin
            nmi_mask_reg <= io_req_i.wdata[NMI_MASK_POS];
        end
    end

    // data port passes straight through to the ram
    always_comb begin
        rtc_req_o.rd    = io_req_i.rd & data_sel;
        rtc_req_o.wr    = io_req_i.wr & data_sel;
        rtc_req_o.addr  = rtc_addr_reg;
        rtc_req_o.wdata = io_req_i.wdata;
    end

    // ==========================================================
    // read data, registered one cycle after the read strobe
    logic [7:0] status_val;
    logic [7:0] index_val;
    logic [7:0] rdata_next;

    // bits 4-7 are status only, writes never reach them
    always_comb begin
        status_val                   = 8'h00;
        status_val[3:0]              = ctrl_reg;
        status_val[REFRESH_POS]      = refresh_reg;
        status_val[TIMER2_OUT_POS]   = t2_level;
        status_val[CHCK_LATCH_POS]   = chck_latch;
        status_val[PARITY_LATCH_POS] = parity_latch;
    end

    always_comb begin
        index_val                 = 8'h00;
        index_val[RTC_ADDR_W-1:0] = rtc_addr_reg;
        index_val[NMI_MASK_POS]   = nmi_mask_reg;
    end

    // unmapped reads return zero so a stray probe sees no stale byte
    always_comb begin
        rdata_next = 8'h00;
        if (status_sel) begin
            rdata_next = status_val;
        end else if (index_sel) begin
            rdata_next = index_val;
        end else if (data_sel) begin
            // ram answers in the same cycle as its read strobe
            rdata_next = rtc_rdata_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            io_rdata_o <= 8'h00;
        end else if (io_req_i.rd) begin
            io_rdata_o <= rdata_next;
        end
    end
endmodule
`default_nettype wire

// File: tb/rtc_ram_model.sv
// behavioural rtc/cmos ram seen through the data port
`timescale 1ns/100ps
`default_nettype none
module rtc_ram_model
    import sysctl_pkg::*;
(
    // ram side of the block
    input  wire logic     core_clk_i,
    input  wire rtc_req_t rtc_req_i,
    output logic [7:0]    rdata_o
);
    logic [7:0] mem [0:127];
    logic [7:0] last_reg = 8'h00;
    // idle bus shows the inverse of the last read, never a stale copy
    assign rdata_o = rtc_req_i.rd ? mem[rtc_req_i.addr] : ~last_reg;
    always_ff @(posedge core_clk_i) begin
        if (rtc_req_i.wr) mem[rtc_req_i.addr] <= rtc_req_i.wdata;
        if (rtc_req_i.rd) last_reg <= mem[rtc_req_i.addr];
    end
endmodule
`default_nettype wire

// File: tb/sysctl_assertions.sv
// concurrent checks on the system control ports
`timescale 1ns/100ps
`default_nettype none
module sysctl_chk
    import sysctl_pkg::*;
(
    // watched ports
    input wire logic       core_clk_i,
    input wire logic       sys_rst_i,
    input wire io_req_t    io_req_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic       io_hit_o,
    input wire logic       timer2_out_i,
    input wire logic       timer2_gate_o,
    input wire logic       speaker_o,
    input wire logic       nmi_o,
    input wire rtc_req_t   rtc_req_o,
    input wire logic [7:0] rtc_rdata_i
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic rd = io_req_i.rd;
    wire logic wr = io_req_i.wr;
    wire logic a61 = io_req_i.addr == SYSCTL_STATUS_ADDR;
    wire logic a70 = io_req_i.addr == RTC_INDEX_ADDR;
    wire logic a71 = io_req_i.addr == RTC_DATA_ADDR;
    // ==========================================================
    // assertions
    chk_hit_decode: assert property (
        io_hit_o == ((rd | wr) && (a61 || a70 || a71))) else $error("hit");
    chk_rtc_read: assert property (rd && a71 |->
        rtc_req_o.rd ##1 io_rdata_o == $past(rtc_rdata_i)) else $error("rr");
    chk_rtc_write: assert property (wr && a71 |->
        rtc_req_o.wr && rtc_req_o.wdata == io_req_i.wdata) else $error("rw");
    chk_index_store: assert property (wr && a70 |=>
        rtc_req_o.addr == $past(io_req_i.wdata[6:0])) else $error("idx");
    chk_index_hold: assert property (!(wr && a70) |=>
        $stable(rtc_req_o.addr)) else $error("idx hold");
    chk_mask_blocks: assert property (wr && a70 && io_req_i.wdata[7]
        |-> ##2 !nmi_o) else $error("mask");
    chk_gate_force: assert property (rd && a61 && !timer2_gate_o
        |=> io_rdata_o[5]) else $error("gate");
    chk_spkr_quiet: assert property (!speaker_o |->
        $past(timer2_out_i) || !$past(timer2_gate_o)) else $error("spk");
    chk_rdata_hold: assert property (!rd |=>
        $stable(io_rdata_o)) else $error("hold");
    chk_unmapped_zero: assert property (rd && !io_hit_o
        |=> io_rdata_o == 8'h00) else $error("unmapped");
    cover property (wr && a70 && io_req_i.wdata[7]);
    cover property ($rose(nmi_o));
    cover property (!speaker_o);
endmodule
bind sysctl_ports sysctl_chk chk_u (.core_clk_i, .sys_rst_i, .io_req_i,
    .io_rdata_o, .io_hit_o, .timer2_out_i, .timer2_gate_o, .speaker_o,
    .nmi_o, .rtc_req_o, .rtc_rdata_i);
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the system control ports
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import sysctl_pkg::*;
    logic       clk = 1'b0, rst = 1'b1, t1 = 1'b0, t2 = 1'b0;
    logic       chk_n = 1'b1, perr = 1'b0, gate, hit, spk, nmi, e5;
    logic [7:0] rdata, ram_d, v;
    io_req_t    req = '0;
    rtc_req_t   rreq;
    int         miscompares = 0, comparisons = 0;
    initial forever #2.5 clk = ~clk;
    sysctl_ports dut_u (.core_clk_i(clk), .sys_rst_i(rst), .io_req_i(req),
        .io_rdata_o(rdata), .io_hit_o(hit), .timer1_pulse_i(t1),
        .timer2_out_i(t2), .timer2_gate_o(gate), .speaker_o(spk),
        .iochck_n_i(chk_n), .parity_err_i(perr), .nmi_o(nmi),
        .rtc_req_o(rreq), .rtc_rdata_i(ram_d));
    rtc_ram_model ram_u (.core_clk_i(clk), .rtc_req_i(rreq), .rdata_o(ram_d));
    // ==========================================================
    // bus tasks
    task automatic cmp(input logic [7:0] g, e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_bit(input logic g, e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // leading step keeps release and next request in separate time steps
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        step(1);
        req = '{1'b0, 1'b1, a, d};
        step(1);
        req = '0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        step(1);
        req = '{1'b1, 1'b0, a, 8'h00};
        step(1);
        req = '0;
        d = rdata;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        rd(SYSCTL_STATUS_ADDR, v);
        cmp(v, 8'h20);
        rd(16'h0062, v);
        cmp(v, 8'h00);
        $display("reset done");
    endtask
    task automatic t_rtc();
        wr(RTC_INDEX_ADDR, 8'h05);
        wr(RTC_DATA_ADDR, 8'ha5);
        wr(RTC_INDEX_ADDR, 8'hfe);
        wr(RTC_DATA_ADDR, 8'h3c);
        wr(RTC_INDEX_ADDR, 8'h85);
        rd(RTC_DATA_ADDR, v);
        cmp(v, 8'ha5);
        rd(RTC_INDEX_ADDR, v);
        cmp(v, 8'h85);
        wr(RTC_INDEX_ADDR, 8'h7e);
        rd(RTC_DATA_ADDR, v);
        cmp(v, 8'h3c);
        $display("rtc done");
    endtask
    task automatic t_refresh();
        wr(SYSCTL_STATUS_ADDR, 8'hf0);
        rd(SYSCTL_STATUS_ADDR, v);
        cmp(v, 8'h20);
        for (int i = 0; i < 3; i++) begin
            step(1);
            t1 = 1'b1;
            step(1);
            t1 = 1'b0;
        end
        rd(SYSCTL_STATUS_ADDR, v);
        cmp(v, 8'h30);
        $display("refresh done");
    endtask
    task automatic t_speaker();
        for (int i = 0; i < 8; i++) begin
            wr(SYSCTL_STATUS_ADDR, {6'h00, i[1:0]});
            t2 = i[2];
            rd(SYSCTL_STATUS_ADDR, v);
            e5 = i[0] ? i[2] : 1'b1;
            cmp_bit(v[5], e5);
            cmp_bit(gate, i[0]);
            cmp_bit(spk, !(i[1] && e5));
        end
        $display("speaker done");
    endtask
    task automatic t_nmi();
        wr(SYSCTL_STATUS_ADDR, 8'h00);
        for (int i = 0; i < 2; i++) begin
            step(1);
            chk_n = 1'b0;
            step(1);
            chk_n = 1'b1;
            rd(SYSCTL_STATUS_ADDR, v);
            cmp_bit(v[6], !i[0]);
            cmp_bit(nmi, !i[0]);
            wr(SYSCTL_STATUS_ADDR, 8'h08);
        end
        wr(SYSCTL_STATUS_ADDR, 8'h00);
        step(1);
        perr = 1'b1;
        step(1);
        perr = 1'b0;
        rd(SYSCTL_STATUS_ADDR, v);
        cmp_bit(v[7], 1'b1);
        cmp_bit(nmi, 1'b1);
        wr(RTC_INDEX_ADDR, 8'h80);
        step(2);
        cmp_bit(nmi, 1'b0);
        wr(SYSCTL_STATUS_ADDR, 8'h04);
        rd(SYSCTL_STATUS_ADDR, v);
        cmp_bit(v[7], 1'b0);
        $display("nmi done");
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatched %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // whole sequence needs well under 2000 cycles
    initial begin
        #100us;
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        t_reset();
        t_rtc();
        t_refresh();
        t_speaker();
        t_nmi();
        complete_run();
    end
endmodule
`default_nettype wire
